/* File: design/pwmuts_pkg.sv */
// Package of register map, field positions and bus carrier for the update trigger select block
package pwmuts_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_TRIG_CFG   = 12'h000;
  localparam logic [11:0] OFS_CTRL       = 12'h004;
  localparam logic [11:0] OFS_PERIOD     = 12'h008;
  localparam logic [11:0] OFS_START      = 12'h00C;
  localparam logic [11:0] OFS_GATE       = 12'h010;
  localparam logic [11:0] OFS_STATUS     = 12'h014;
  localparam logic [11:0] OFS_MATCH_BASE = 12'h020;
  localparam int          MATCH_STRIDE   = 4;
  localparam int          ADDR_W         = 12;

  // ----------------------------------------------------------------
  // Field positions of update_trigger_config
  // ----------------------------------------------------------------
  localparam int BIT_SOFT_REQ   = 7;
  localparam int BIT_HW2_EN     = 6;
  localparam int BIT_HW1_EN     = 5;
  localparam int BIT_HW0_EN     = 4;
  localparam int BIT_GATE_SEL   = 3;
  localparam int BIT_RESTART    = 2;
  localparam int BIT_TOP_LOAD   = 1;
  localparam int BIT_BOTTOM_LD  = 0;
  localparam int CFG_W          = 8;
  localparam int HW_LSB         = 4;
  localparam int N_HW           = 3;

  // ----------------------------------------------------------------
  // Field positions of the control register
  // ----------------------------------------------------------------
  localparam int CBIT_RESTRICT  = 0;
  localparam int CBIT_ENHANCED  = 1;
  localparam int CBIT_CNT_EN    = 2;
  localparam int CTRL_W         = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CFG_W-1:0]  CFG_RST  = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [31:0]       ZERO32   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // APB request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } pwmuts_apb_req_t;

endpackage : pwmuts_pkg

/* File: design/pwmuts_top.sv */
// Update trigger selection for a buffered PWM timer, with APB register access
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// How it works
// R1: A sync event copies buffers into period, match, gate and may restart counter.
// R2: Config bit 7 written 1 raises a software sync trigger; 0 leaves it unselected.
// R3: Config bit 6 enables rising edges of hardware trigger 2 as a source.
// R4: Config bit 5 enables rising edges of hardware trigger 1 as a source.
// R5: Config bit 4 enables rising edges of hardware trigger 0 as a source.
// R6: Bit 3 clear loads gate every clock; set loads gate only on sync.
// R7: Bit 2 set, enhanced off: counter restarts at start value on trigger.
// R8: Bit 1 set makes counter reaching period limit a loading point.
// R9: Bit 0 set makes counter reaching start value a loading point.
// R10: Config bits 31 to 8 are read-only and read as zero.
// R11: Loading points update period, start and all match values together.
// R12: Software should not mix software and hardware triggers with enhanced off.
// R13: Software should not mix loading points with hardware triggers, enhanced off.
// R14: Routing restricted: software feeds period/match, hardware feeds gate/counter.
// R15: Any one enabled, detected trigger counts as a sync trigger.
module pwmuts_top #(
  parameter int CNT_W = 16,
  parameter int N_CH  = 8
) (
  // Clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    rst_in,
  // APB slave
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [11:0]             paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic                         pready_out,
  output logic                         pslverr_out,
  output logic [31:0]                  prdata_out,
  // Hardware trigger pins
  input  wire logic [2:0]              hw_trig_in,
  // Active timer values
  output logic [CNT_W-1:0]             counter_out,
  output logic [CNT_W-1:0]             period_limit_out,
  output logic [CNT_W-1:0]             start_value_out,
  output logic [N_CH*CNT_W-1:0]        match_value_out,
  output logic [N_CH-1:0]              output_gate_out,
  // Event pulses
  output logic                         sync_update_out,
  output logic                         counter_restart_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [pwmuts_pkg::CFG_W-1:0]  cfg;
    logic [pwmuts_pkg::CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0]              period_buf;
    logic [CNT_W-1:0]              start_buf;
    logic [N_CH-1:0]               gate_buf;
    logic [N_CH-1:0][CNT_W-1:0]    match_buf;
    logic [CNT_W-1:0]              period;
    logic [CNT_W-1:0]              start;
    logic [N_CH-1:0][CNT_W-1:0]    match;
    logic [N_CH-1:0]               gate;
    logic [CNT_W-1:0]              cnt;
    logic                          reg_pend;
    logic                          sw_event;
    logic [pwmuts_pkg::N_HW-1:0]   hw_s1;
    logic [pwmuts_pkg::N_HW-1:0]   hw_s2;
    logic [pwmuts_pkg::N_HW-1:0]   hw_s3;
    logic [pwmuts_pkg::N_HW-1:0]   hw_lvl;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
    logic                          sync_pulse;
    logic                          restart_pulse;
  } pwmuts_state_t;

  pwmuts_state_t            s_r;
  pwmuts_state_t            s_nxt;
  pwmuts_pkg::pwmuts_apb_req_t req;

  assign req.psel    = psel_in;
  assign req.penable = penable_in;
  assign req.pwrite  = pwrite_in;
  assign req.paddr   = paddr_in;
  assign req.pwdata  = pwdata_in;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  // Returns channel index plus one for a match buffer address, else zero
  function automatic int match_slot(input logic [11:0] addr);
    int slot;
    slot = 0;
    for (int i = 0; i < N_CH; i++) begin
      if (addr == pwmuts_pkg::OFS_MATCH_BASE + 12'(i * pwmuts_pkg::MATCH_STRIDE)) begin
        slot = i + 1;
      end
    end
    return slot;
  endfunction : match_slot

  function automatic logic is_mapped(input logic [11:0] addr);
    return (addr == pwmuts_pkg::OFS_TRIG_CFG) || (addr == pwmuts_pkg::OFS_CTRL) ||
           (addr == pwmuts_pkg::OFS_PERIOD)   || (addr == pwmuts_pkg::OFS_START) ||
           (addr == pwmuts_pkg::OFS_GATE)     || (addr == pwmuts_pkg::OFS_STATUS) ||
           (match_slot(addr) != 0);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic                        acc;
    logic                        wr_commit;
    logic [31:0]                 rd;
    int                          slot;
    logic                        enh;
    logic                        restrict_rt;
    logic [pwmuts_pkg::N_HW-1:0] hw_en;
    logic [pwmuts_pkg::N_HW-1:0] hw_rise;
    logic                        hw_fire;
    logic                        sw_fire;
    logic                        reg_trig;
    logic                        cnt_trig;
    logic                        top_pt;
    logic                        bottom_pt;
    logic                        any_pt_en;
    logic                        reg_load;
    logic                        restart;
    logic [CNT_W-1:0]            new_start;
    acc         = 1'b0;
    wr_commit   = 1'b0;
    rd          = pwmuts_pkg::ZERO32;
    slot        = 0;
    enh         = 1'b0;
    restrict_rt = 1'b0;
    hw_en       = '0;
    hw_rise     = '0;
    hw_fire     = 1'b0;
    sw_fire     = 1'b0;
    reg_trig    = 1'b0;
    cnt_trig    = 1'b0;
    top_pt      = 1'b0;
    bottom_pt   = 1'b0;
    any_pt_en   = 1'b0;
    reg_load    = 1'b0;
    restart     = 1'b0;
    new_start   = '0;
    s_nxt       = s_r;

    // ----------------------------------------------------------------
    // Trigger pin synchronisers
    // ----------------------------------------------------------------
    // Three stages; level moves only when stages two and three agree
    s_nxt.hw_s1 = hw_trig_in;
    s_nxt.hw_s2 = s_r.hw_s1;
    s_nxt.hw_s3 = s_r.hw_s2;
    for (int i = 0; i < pwmuts_pkg::N_HW; i++) begin
      if (s_r.hw_s2[i] == s_r.hw_s3[i]) begin
        s_nxt.hw_lvl[i] = s_r.hw_s3[i];
      end
    end
    hw_rise = s_nxt.hw_lvl & ~s_r.hw_lvl;

    // ----------------------------------------------------------------
    // Trigger selection
    // ----------------------------------------------------------------
    enh         = s_r.ctrl[pwmuts_pkg::CBIT_ENHANCED];
    restrict_rt = s_r.ctrl[pwmuts_pkg::CBIT_RESTRICT] && !enh;
    // R3: Trigger 2 enable
    // R4: Trigger 1 enable
    // R5: Trigger 0 enable
    hw_en   = s_r.cfg[pwmuts_pkg::BIT_HW2_EN:pwmuts_pkg::HW_LSB];
    // R15: Any source fires
    hw_fire = |(hw_rise & hw_en);
    // R2: Software trigger event
    sw_fire = s_r.sw_event;
    // R14: Restricted routing
    if (restrict_rt) begin
      reg_trig = sw_fire;
      cnt_trig = hw_fire;
    end else begin
      reg_trig = sw_fire || hw_fire;
      cnt_trig = sw_fire || hw_fire;
    end

    // ----------------------------------------------------------------
    // Loading points
    // ----------------------------------------------------------------
    // R8: Top loading point
    top_pt    = s_r.cfg[pwmuts_pkg::BIT_TOP_LOAD] && (s_r.cnt == s_r.period);
    // R9: Bottom loading point
    bottom_pt = s_r.cfg[pwmuts_pkg::BIT_BOTTOM_LD] && (s_r.cnt == s_r.start);
    any_pt_en = s_r.cfg[pwmuts_pkg::BIT_TOP_LOAD] || s_r.cfg[pwmuts_pkg::BIT_BOTTOM_LD];
    // Without a loading point the update is applied at the trigger itself
    reg_load  = (reg_trig || s_r.reg_pend) && (!any_pt_en || top_pt || bottom_pt);
    if (reg_load) begin
      s_nxt.reg_pend = 1'b0;
    end else if (reg_trig) begin
      s_nxt.reg_pend = 1'b1;
    end

    // R1: Synchronized buffer copy
    // R11: All values at once
    if (reg_load) begin
      s_nxt.period = s_r.period_buf;
      s_nxt.start  = s_r.start_buf;
      s_nxt.match  = s_r.match_buf;
    end
    new_start = reg_load ? s_r.start_buf : s_r.start;

    // R6: Gate load select
    if (!s_r.cfg[pwmuts_pkg::BIT_GATE_SEL]) begin
      s_nxt.gate = s_r.gate_buf;
    end else if (cnt_trig) begin
      s_nxt.gate = s_r.gate_buf;
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // R7: Restart on trigger
    restart = cnt_trig && s_r.cfg[pwmuts_pkg::BIT_RESTART] && !enh;
    if (restart) begin
      s_nxt.cnt = new_start;
    end else if (s_r.ctrl[pwmuts_pkg::CBIT_CNT_EN]) begin
      s_nxt.cnt = (s_r.cnt == s_r.period) ? new_start : s_r.cnt + CNT_W'(1);
    end
    s_nxt.sync_pulse    = reg_load || (cnt_trig && s_r.cfg[pwmuts_pkg::BIT_GATE_SEL]);
    s_nxt.restart_pulse = restart;

    // Soft request bit falls once its update is applied
    s_nxt.sw_event = 1'b0;
    if (reg_load || (restrict_rt == 1'b0 && sw_fire && !any_pt_en)) begin
      s_nxt.cfg[pwmuts_pkg::BIT_SOFT_REQ] = 1'b0;
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    acc       = req.psel && req.penable;
    wr_commit = acc && s_r.pready && req.pwrite && !s_r.pslverr;
    slot      = match_slot(req.paddr);
    s_nxt.pready  = acc && !s_r.pready;
    s_nxt.pslverr = acc && !s_r.pready && !is_mapped(req.paddr);
    // R10: Upper bits read zero
    case (req.paddr)
      pwmuts_pkg::OFS_TRIG_CFG: rd = {24'h00_0000, s_r.cfg};
      pwmuts_pkg::OFS_CTRL:     rd = 32'(s_r.ctrl);
      pwmuts_pkg::OFS_PERIOD:   rd = 32'(s_r.period_buf);
      pwmuts_pkg::OFS_START:    rd = 32'(s_r.start_buf);
      pwmuts_pkg::OFS_GATE:     rd = 32'(s_r.gate_buf);
      pwmuts_pkg::OFS_STATUS:   rd = {15'h0000, s_r.reg_pend, 16'(s_r.cnt)};
      default: begin
        rd = (slot != 0) ? 32'(s_r.match_buf[slot-1]) : pwmuts_pkg::ZERO32;
      end
    endcase
    s_nxt.prdata = (acc && !s_r.pready && !req.pwrite) ? rd : pwmuts_pkg::ZERO32;

    if (wr_commit) begin
      case (req.paddr)
        pwmuts_pkg::OFS_TRIG_CFG: begin
          s_nxt.cfg[pwmuts_pkg::BIT_SOFT_REQ-1:0] =
            req.pwdata[pwmuts_pkg::BIT_SOFT_REQ-1:0];
          // R2: Writing one requests
          if (req.pwdata[pwmuts_pkg::BIT_SOFT_REQ]) begin
            s_nxt.cfg[pwmuts_pkg::BIT_SOFT_REQ] = 1'b1;
            s_nxt.sw_event                       = 1'b1;
          end
        end
        pwmuts_pkg::OFS_CTRL:   s_nxt.ctrl       = req.pwdata[pwmuts_pkg::CTRL_W-1:0];
        pwmuts_pkg::OFS_PERIOD: s_nxt.period_buf = req.pwdata[CNT_W-1:0];
        pwmuts_pkg::OFS_START:  s_nxt.start_buf  = req.pwdata[CNT_W-1:0];
        pwmuts_pkg::OFS_GATE:   s_nxt.gate_buf   = req.pwdata[N_CH-1:0];
        default: begin
          if (slot != 0) begin
            s_nxt.match_buf[slot-1] = req.pwdata[CNT_W-1:0];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_r      <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready_out          = s_r.pready;
  assign pslverr_out         = s_r.pslverr;
  assign prdata_out          = s_r.prdata;
  assign counter_out         = s_r.cnt;
  assign period_limit_out    = s_r.period;
  assign start_value_out     = s_r.start;
  assign match_value_out     = s_r.match;
  assign output_gate_out     = s_r.gate;
  assign sync_update_out     = s_r.sync_pulse;
  assign counter_restart_out = s_r.restart_pulse;

endmodule : pwmuts_top

/* File: tb/pwmuts_monitor.sv */
// Assertion checker for the update trigger select block
`timescale 1ns/1ps
module pwmuts_monitor #(
  parameter int N_CH = 8
) (
  // Clock, reset and bus
  input wire logic            mclk_in,
  input wire logic            rst_in,
  input wire logic            psel_in,
  input wire logic            penable_in,
  input wire logic            pwrite_in,
  input wire logic [11:0]     paddr_in,
  input wire logic [31:0]     pwdata_in,
  input wire logic            pready_out,
  input wire logic            pslverr_out,
  input wire logic [31:0]     prdata_out,
  // Triggers and results
  input wire logic [2:0]      hw_trig_in,
  input wire logic [N_CH-1:0] output_gate_out,
  input wire logic            sync_update_out,
  input wire logic            counter_restart_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [7:0]      cfg_r;
  logic [2:0]      ctl_r;
  logic [N_CH-1:0] gate_r;
  logic            wr_ok;
  assign wr_ok = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;
  // Mirrors of written settings; bit 7 does not self-clear here, so it is unused
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cfg_r <= 8'h00;
      ctl_r <= 3'h0;
      gate_r <= '0;
    end else if (wr_ok) begin
      if (paddr_in == pwmuts_pkg::OFS_TRIG_CFG) cfg_r <= pwdata_in[7:0];
      if (paddr_in == pwmuts_pkg::OFS_CTRL) ctl_r <= pwdata_in[2:0];
      if (paddr_in == pwmuts_pkg::OFS_GATE) gate_r <= pwdata_in[N_CH-1:0];
    end
  end
  a_ready_after_access: assert property (pready_out |-> psel_in && penable_in
    && $past(psel_in && penable_in)) else $error("ready without two access cycles");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data not zero when idle");
  a_cfg_upper_zero: assert property (
    pready_out && !pwrite_in && paddr_in == pwmuts_pkg::OFS_TRIG_CFG
    |-> prdata_out[31:8] == 24'h00_0000) else $error("reserved bits not zero");
  a_soft_trig_update: assert property (
    wr_ok && paddr_in == pwmuts_pkg::OFS_TRIG_CFG && pwdata_in[7]
    && pwdata_in[1:0] == 2'b00 |-> ##[1:4] sync_update_out)
    else $error("software trigger gave no update");
  a_hw_trig_update: assert property (
    (|(hw_trig_in & ~$past(hw_trig_in) & cfg_r[6:4])) && cfg_r[1:0] == 2'b00
    && !ctl_r[0] |-> ##[2:8] sync_update_out) else $error("hardware edge gave no update");
  a_gate_follows: assert property (
    (!cfg_r[3] && $stable(gate_r))[*3] |-> output_gate_out == gate_r)
    else $error("gate does not follow buffer");
  a_restart_cause: assert property (
    counter_restart_out |-> cfg_r[2] && !ctl_r[1]) else $error("restart not enabled");
endmodule : pwmuts_monitor

bind pwmuts_top pwmuts_monitor #(.N_CH(N_CH)) u_mon (
  .mclk_in             (mclk_in),
  .rst_in              (rst_in),
  .psel_in             (psel_in),
  .penable_in          (penable_in),
  .pwrite_in           (pwrite_in),
  .paddr_in            (paddr_in),
  .pwdata_in           (pwdata_in),
  .pready_out          (pready_out),
  .pslverr_out         (pslverr_out),
  .prdata_out          (prdata_out),
  .hw_trig_in          (hw_trig_in),
  .output_gate_out     (output_gate_out),
  .sync_update_out     (sync_update_out),
  .counter_restart_out (counter_restart_out)
);

/* File: tb/pwmuts_tb_top.sv */
// Self-checking bench for the update trigger select block
`timescale 1ns/1ps
module pwmuts_tb_top;
  localparam logic [11:0] A_CFG = pwmuts_pkg::OFS_TRIG_CFG;
  localparam logic [11:0] A_PER = pwmuts_pkg::OFS_PERIOD;
  localparam logic [11:0] A_MAT = pwmuts_pkg::OFS_MATCH_BASE;
  logic         mclk_in = 1'b0;
  logic         rst_in  = 1'b1;
  logic         psel    = 1'b0;
  logic         pen     = 1'b0;
  logic         pwr     = 1'b0;
  logic [11:0]  padr    = 12'h000;
  logic [31:0]  pwd     = 32'h0000_0000;
  logic [2:0]   hw      = 3'h0;
  logic [31:0]  seed    = 32'h0000_A39F;
  logic         prdy, perr, syn, rst_p, e;
  logic [31:0]  prd, q, v;
  logic [15:0]  cnt, per, stv, pe, op, pc;
  logic [127:0] mat, mx;
  logic [7:0]   gate;
  int           n_mismatch = 0;
  int           num_checks = 0;
  int           cyc        = 0;

  pwmuts_top #(.CNT_W(16), .N_CH(8)) DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .pready_out(prdy),
    .pslverr_out(perr), .prdata_out(prd), .hw_trig_in(hw), .counter_out(cnt),
    .period_limit_out(per), .start_value_out(stv), .match_value_out(mat),
    .output_gate_out(gate), .sync_update_out(syn), .counter_restart_out(rst_p));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial forever #5 mclk_in = ~mclk_in;
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge mclk_in);
    pen <= 1'b1;
    // No assumed latency; only the hang guard ends a stuck wait
    do begin
      @(posedge mclk_in);
    end while (prdy !== 1'b1);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk_in);
  endtask : apb
  task automatic wait_sync(output logic [15:0] c);
    c = cnt;
    while (syn !== 1'b1) begin
      c = cnt;
      @(posedge mclk_in);
    end
  endtask : wait_sync
  task automatic quiet(input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge mclk_in);
      s = s | syn;
    end
    chk(s, 1'b0);
  endtask : quiet

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    apb(1'b0, A_CFG, 0);
    chk(q, 0);
    for (int i = 0; i < 4; i++) begin
      v = rnd() | 32'hFFFF_FF00;
      v[7] = 1'b0;
      // No loading points with hardware triggers
      if (|v[6:4]) v[1:0] = 2'b00;
      apb(1'b1, A_CFG, v);
      apb(1'b0, A_CFG, 0);
      chk(q, v[6:0]);
    end
    apb(1'b1, 12'hFFC, v);
    chk(e, 1'b1);
    apb(1'b0, 12'hFFC, 0);
    chk({e, q}, {1'b1, 32'h0000_0000});
    apb(1'b1, pwmuts_pkg::OFS_START, 16'h0008);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      mx[i*16 +: 16] = v[15:0];
      apb(1'b1, A_MAT + 12'(4 * i), v[15:0]);
    end
    pe = 16'h0030 | v[19:16];
    apb(1'b1, A_PER, pe);
    apb(1'b1, pwmuts_pkg::OFS_GATE, v[31:24]);
    apb(1'b1, A_CFG, 8'h88);
    wait_sync(pc);
    chk({per, stv, gate}, {pe, 16'h0008, v[31:24]});
    chk(mat, mx);
    apb(1'b0, A_CFG, 0);
    chk(q, 8'h08);
    apb(1'b1, A_CFG, 8'h00);
    v = rnd();
    apb(1'b1, pwmuts_pkg::OFS_GATE, v[7:0]);
    repeat (2) @(posedge mclk_in);
    chk(gate, v[7:0]);
    apb(1'b1, A_CFG, 8'h08);
    apb(1'b1, pwmuts_pkg::OFS_GATE, ~v[7:0]);
    repeat (4) @(posedge mclk_in);
    chk(gate, v[7:0]);
    apb(1'b1, pwmuts_pkg::OFS_CTRL, 3'h4);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, A_CFG, 8'h7C);
      v = rnd();
      pe = 16'h0020 | v[3:0];
      apb(1'b1, A_PER, pe);
      hw[i] <= 1'b1;
      wait_sync(pc);
      chk({per, rst_p, cnt}, {pe, 1'b1, 16'h0008});
      hw[i] <= 1'b0;
      apb(1'b1, A_CFG, 8'h7C ^ (8'h10 << i));
      hw[i] <= 1'b1;
      quiet(12);
      hw[i] <= 1'b0;
      repeat (6) @(posedge mclk_in);
    end
    apb(1'b1, pwmuts_pkg::OFS_CTRL, 3'h6);
    apb(1'b1, A_CFG, 8'h14);
    hw[0] <= 1'b1;
    wait_sync(pc);
    chk(rst_p, 1'b0);
    hw[0] <= 1'b0;
    apb(1'b1, pwmuts_pkg::OFS_CTRL, 3'h4);
    for (int k = 0; k < 2; k++) begin
      v = rnd();
      op = pe;
      pe = 16'h0020 | v[3:0];
      apb(1'b1, A_PER, pe);
      apb(1'b1, A_MAT, v[31:16]);
      // Loading points with soft trigger only
      apb(1'b1, A_CFG, 8'h80 | (8'h02 >> k));
      wait_sync(pc);
      chk(pc, k == 0 ? op : 16'h0008);
      chk({per, mat[15:0]}, {pe, v[31:16]});
    end
    apb(1'b1, pwmuts_pkg::OFS_CTRL, 3'h5);
    v = rnd();
    apb(1'b1, pwmuts_pkg::OFS_GATE, v[7:0]);
    apb(1'b1, A_CFG, 8'h08);
    apb(1'b1, pwmuts_pkg::OFS_GATE, v[15:8]);
    pe = 16'h0020 | v[19:16];
    apb(1'b1, A_PER, pe);
    apb(1'b1, A_CFG, 8'h88);
    wait_sync(pc);
    chk({per, gate}, {pe, v[7:0]});
    apb(1'b1, A_PER, 16'h0040);
    apb(1'b1, A_CFG, 8'h1C);
    hw[0] <= 1'b1;
    wait_sync(pc);
    chk({per, gate, rst_p, cnt}, {pe, v[15:8], 1'b1, 16'h0008});
    hw[0] <= 1'b0;
    results();
  end
endmodule : pwmuts_tb_top
